//--- hw/line_readout_pkg.sv
// package for the linear sensor line readout controller
// assumes a 125 MHz system clock; all pixel timing derives from it
package line_readout_pkg;
  localparam int unsigned SYS_CLK_HZ = 125000000;
  localparam int unsigned SYS_PERIOD_NS = 8;
  // pixel clock limits and defaults
  localparam int unsigned PIX_FREQ_MAX_KHZ = 5000;
  localparam int unsigned PIX_FREQ_TYP_KHZ = 2000;
  localparam int unsigned PIX_PHASE_MIN_NS = 100;
  localparam int unsigned PIX_DUTY_MIN_PCT = 40;
  localparam int unsigned PIX_DUTY_MAX_PCT = 60;
  // default half period: typical 2 MHz -> 250 ns per phase
  localparam int unsigned PIX_HALF_TYP_NS = 250;
  localparam int unsigned PIX_HALF_TYP_CYC = PIX_HALF_TYP_NS / SYS_PERIOD_NS;
  // least phase in cycles, rounded up
  localparam int unsigned PIX_PHASE_MIN_CYC = (PIX_PHASE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // gate pulse width and clock-to-gate spacing
  localparam int unsigned GATE_MIN_NS = 500;
  localparam int unsigned GATE_TYP_NS = 1000;
  localparam int unsigned GATE_TYP_CYC = GATE_TYP_NS / SYS_PERIOD_NS;
  localparam int unsigned GATE_MIN_CYC = (GATE_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned GUARD_MIN_NS = 10;
  localparam int unsigned GUARD_CYC = (GUARD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // recommended longest integration: 10 ms
  localparam int unsigned INTEG_MAX_US = 10000;
  localparam int unsigned INTEG_MAX_CYC = INTEG_MAX_US * (SYS_CLK_HZ / 1000000);
  // line layout
  localparam int unsigned LEAD_DUMMY = 32;
  localparam int unsigned ACTIVE_PIX = 2048;
  localparam int unsigned TRAIL_DUMMY = 6;
  localparam int unsigned LINE_PIX = LEAD_DUMMY + ACTIVE_PIX + TRAIL_DUMMY;
  localparam int unsigned PIX_CNT_W = 12;
  typedef enum logic [1:0] {
    REGION_LEAD = 2'b00,
    REGION_ACTIVE = 2'b01,
    REGION_TRAIL = 2'b10,
    REGION_IDLE = 2'b11
  } region_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GUARD_IN = 3'b001,
    ST_GATE = 3'b010,
    ST_GUARD_OUT = 3'b011,
    ST_CLK_HIGH = 3'b100,
    ST_CLK_LOW = 3'b101,
    ST_WAIT = 3'b110
  } seq_state_t;
  // tag carried with every pixel strobe
  typedef struct packed {
    logic [PIX_CNT_W-1:0] index;
    region_t region;
    logic line_odd;
    logic keep;
  } pixel_tag_t;
endpackage

//--- hw/line_readout_ctrl.sv
// timing controller that drives a 2086-pixel linear sensor: gate and pixel clock
// assumes an external ADC clocked by adc_clk samples the video and hands in words
//
// Contract
// - pixel clock no faster than 5 MHz
// - pixel clock duty between 40 and 60
// - each clock phase at least 100 ns
// - gate pulse at least 500 ns low
// - 10 ns between clock and gate edges
// - hold mode pin low enables sample-hold
// - only gate and pixel clock are driven; the block also drives hold_mode_select
// - a line is 2086 pixel clock periods
// - optionally keep only every other line
// - gate spacing yields alternate long integrations
// - integration interval at most 10 ms
// - gate low ends integration, starts readout
`timescale 1ns/1ps
module line_readout_ctrl
  import line_readout_pkg::*;
#(
  parameter int unsigned HALF_CYC = PIX_HALF_TYP_CYC,
  parameter int unsigned GATE_CYC = GATE_TYP_CYC,
  parameter int unsigned INTEG_CYC = INTEG_MAX_CYC,
  parameter int unsigned ADC_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic adc_clk,
  input wire logic start,
  input wire logic continuous,
  input wire logic sample_hold,
  input wire logic alternate_only,
  input wire logic [ADC_W-1:0] adc_data,
  output logic readout_gate_n,
  output logic pixel_clk,
  output logic hold_mode_select,
  output logic busy,
  output logic pix_valid,
  output logic [ADC_W-1:0] pix_data,
  output pixel_tag_t pix_tag
);

  // cycle counters sized for the longest count (integration)
  localparam int unsigned CNT_W = $clog2(INTEG_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] HALF_N = CNT_W'(HALF_CYC < PIX_PHASE_MIN_CYC ? PIX_PHASE_MIN_CYC : HALF_CYC);
  localparam logic [CNT_W-1:0] GATE_N = CNT_W'(GATE_CYC < GATE_MIN_CYC ? GATE_MIN_CYC : GATE_CYC);
  localparam logic [CNT_W-1:0] GUARD_N = CNT_W'(GUARD_CYC);
  localparam logic [CNT_W-1:0] INTEG_N = CNT_W'(INTEG_CYC);
  localparam logic [PIX_CNT_W-1:0] LINE_N = PIX_CNT_W'(LINE_PIX);
  localparam logic [PIX_CNT_W-1:0] LEAD_N = PIX_CNT_W'(LEAD_DUMMY);
  localparam logic [PIX_CNT_W-1:0] ACT_END = PIX_CNT_W'(LEAD_DUMMY + ACTIVE_PIX);

  seq_state_t state_reg, state_next;
  logic [CNT_W-1:0] phase_reg, phase_next;
  logic [CNT_W-1:0] integ_reg, integ_next;
  logic [PIX_CNT_W-1:0] pix_reg, pix_next;
  logic gate_n_reg, gate_n_next;
  logic clk_reg, clk_next;
  logic odd_reg, odd_next;
  logic busy_reg, busy_next;
  logic hold_reg, hold_next;
  logic fall_evt;
  logic integ_done;

  // integration ceiling: in continuous mode the next gate falls INTEG_N + GUARD_N + 1 cycles after the last, if the line is read out by then
  assign integ_done = (integ_reg >= INTEG_N - CNT_W'(1));

  // line sequencer: guard, gate low, guard, then clock the line out
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg + CNT_W'(1);
    integ_next = (integ_reg == {CNT_W{1'b1}}) ? integ_reg : integ_reg + CNT_W'(1);
    pix_next = pix_reg;
    gate_n_next = gate_n_reg;
    clk_next = clk_reg;
    odd_next = odd_reg;
    busy_next = busy_reg;
    hold_next = hold_reg;
    fall_evt = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        busy_next = 1'b0;
        clk_next = 1'b1;
        hold_next = ~sample_hold; // ground selects sample-hold; only changed between lines
        if (start) begin
          busy_next = 1'b1;
          phase_next = '0;
          state_next = ST_GUARD_IN;
        end
      end
      ST_GUARD_IN: begin
        if (phase_reg >= GUARD_N) begin
          gate_n_next = 1'b0;
          phase_next = '0;
          integ_next = '0;
          odd_next = ~odd_reg; // tracks which storage register holds the line
          state_next = ST_GATE;
        end
      end
      ST_GATE: begin
        if (phase_reg >= GATE_N - CNT_W'(1)) begin
          gate_n_next = 1'b1;
          phase_next = '0;
          state_next = ST_GUARD_OUT;
        end
      end
      ST_GUARD_OUT: begin
        if (phase_reg >= GUARD_N) begin
          phase_next = '0;
          pix_next = '0; // counter restarts with each gate
          clk_next = 1'b0; // first falling edge presents pixel 0
          fall_evt = 1'b1;
          state_next = ST_CLK_LOW;
        end
      end
      ST_CLK_LOW: begin
        if (phase_reg >= HALF_N - CNT_W'(1)) begin // equal halves give 50 percent
          phase_next = '0;
          clk_next = 1'b1;
          state_next = ST_CLK_HIGH;
        end
      end
      ST_CLK_HIGH: begin
        if (phase_reg >= HALF_N - CNT_W'(1)) begin // period is 2*HALF_N >= 200 ns
          phase_next = '0;
          if (pix_reg == LINE_N - PIX_CNT_W'(1)) begin // 2086 periods per line
            state_next = ST_WAIT;
          end else begin
            pix_next = pix_reg + PIX_CNT_W'(1);
            clk_next = 1'b0;
            fall_evt = 1'b1;
            state_next = ST_CLK_LOW;
          end
        end
      end
      ST_WAIT: begin
        // clock parks high; next gate comes on start or, in continuous mode, at the integration ceiling
        if ((continuous && integ_done) || start) begin
          phase_next = '0;
          state_next = ST_GUARD_IN;
        end else if (!continuous) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      integ_reg <= '0;
      pix_reg <= '0;
      gate_n_reg <= 1'b1;
      clk_reg <= 1'b1;
      odd_reg <= 1'b1;
      busy_reg <= 1'b0;
      hold_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      integ_reg <= integ_next;
      pix_reg <= pix_next;
      gate_n_reg <= gate_n_next;
      clk_reg <= clk_next;
      odd_reg <= odd_next;
      busy_reg <= busy_next;
      hold_reg <= hold_next;
    end
  end

  // two timing pins, the static mode strap and busy leave the block here
  assign readout_gate_n = gate_n_reg;
  assign pixel_clk = clk_reg;
  assign hold_mode_select = hold_reg;
  assign busy = busy_reg;

  // pixel index that the video shows: sample-hold lags one period
  // taken from the counter's next value; the old value still names the previous pixel
  logic [PIX_CNT_W-1:0] shown_idx;
  logic shown_ok;
  always_comb begin
    shown_idx = pix_next;
    shown_ok = fall_evt;
    if (!hold_reg) begin
      shown_idx = pix_next - PIX_CNT_W'(1);
      shown_ok = fall_evt && (pix_next != '0);
    end
  end

  // tag region from index drop every other line if asked
  pixel_tag_t tag_next;
  always_comb begin
    tag_next.index = shown_idx;
    tag_next.line_odd = odd_reg;
    tag_next.keep = ~alternate_only | ~odd_reg;
    if (shown_idx < LEAD_N) begin
      tag_next.region = REGION_LEAD;
    end else if (shown_idx < ACT_END) begin
      tag_next.region = REGION_ACTIVE;
    end else begin
      tag_next.region = REGION_TRAIL;
    end
  end

  // rst is a sys_clk level; stretching it lets two slow adc_clk edges see even a short pulse
  // limitation: an adc clock slower than 8 sys_clk cycles per period needs a longer stretch
  localparam logic [4:0] RST_STRETCH = 5'h10;
  logic [4:0] stretch_reg, stretch_next;
  logic adc_rst_req_reg, adc_rst_req_next;
  always_comb begin
    stretch_next = (stretch_reg == 5'h0) ? 5'h0 : stretch_reg - 5'h1;
    adc_rst_req_next = (stretch_reg != 5'h0);
    if (rst) begin
      stretch_next = RST_STRETCH;
      adc_rst_req_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    stretch_reg <= stretch_next;
    adc_rst_req_reg <= adc_rst_req_next;
  end

  // two-flop synchroniser brings the reset request into the adc domain
  logic adc_rst_meta_reg, adc_rst_reg;
  always_ff @(posedge adc_clk) begin
    adc_rst_meta_reg <= adc_rst_req_reg;
    adc_rst_reg <= adc_rst_meta_reg;
  end

  // adc words cross by two-flop sync then capture at the next falling edge event;
  // the adc runs free so its sample stays stable for many sys_clk cycles
  logic [ADC_W-1:0] adc_cap_reg;
  logic [ADC_W-1:0] sync1_reg, sync2_reg, sync2_next;
  logic tgl_reg, tsync1_reg, tsync2_reg, tsync3_reg;
  logic tgl_next;
  assign tgl_next = ~tgl_reg;
  always_ff @(posedge adc_clk) begin
    if (adc_rst_reg) begin
      adc_cap_reg <= '0;
      tgl_reg <= 1'b0;
    end else begin
      adc_cap_reg <= adc_data;
      tgl_reg <= tgl_next;
    end
  end

  // toggle marks a fresh word; data is taken one sync stage after the toggle settles
  logic word_new;
  assign word_new = tsync3_reg ^ tsync2_reg;
  always_comb begin
    sync2_next = sync2_reg;
    if (word_new) begin
      sync2_next = sync1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tsync1_reg <= 1'b0;
      tsync2_reg <= 1'b0;
      tsync3_reg <= 1'b0;
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      tsync1_reg <= tgl_reg;
      tsync2_reg <= tsync1_reg;
      tsync3_reg <= tsync2_reg;
      sync1_reg <= adc_cap_reg;
      sync2_reg <= sync2_next;
    end
  end

  // pixel strobe: one cycle per falling edge, tagged; in sample-hold mode the first falling edge of a line gives none
  logic valid_reg, valid_next;
  logic [ADC_W-1:0] data_reg, data_next;
  pixel_tag_t tag_reg, tag_reg_next;
  always_comb begin
    valid_next = shown_ok;
    data_next = shown_ok ? sync2_reg : data_reg;
    tag_reg_next = shown_ok ? tag_next : tag_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid_reg <= 1'b0;
      data_reg <= '0;
      tag_reg <= '{index: '0, region: REGION_IDLE, line_odd: 1'b0, keep: 1'b0};
    end else begin
      valid_reg <= valid_next;
      data_reg <= data_next;
      tag_reg <= tag_reg_next;
    end
  end

  assign pix_valid = valid_reg;
  assign pix_data = data_reg;
  assign pix_tag = tag_reg;

endmodule

//--- tb/line_readout_ctrl_asserts.sv
// pin-level assertions for the line readout controller
// assumes bind onto line_readout_ctrl; one clock domain
`timescale 1ns/1ps
module line_readout_ctrl_asserts
  import line_readout_pkg::*;
#(
  parameter int unsigned HALF_CYC = PIX_HALF_TYP_CYC,
  parameter int unsigned GATE_CYC = GATE_TYP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic alternate_only,
  input wire logic readout_gate_n,
  input wire logic pixel_clk,
  input wire logic hold_mode_select,
  input wire logic busy,
  input wire logic pix_valid,
  input wire pixel_tag_t pix_tag
);
  logic [19:0] lo_reg, hi_reg, gl_reg;
  // phase lengths in cycles; far too long for repetition
  always_ff @(posedge sys_clk) begin
    lo_reg <= (rst || pixel_clk) ? 20'h0 : lo_reg + 20'h1;
    hi_reg <= (rst || !pixel_clk) ? 20'h0 : hi_reg + 20'h1;
    gl_reg <= (rst || readout_gate_n) ? 20'h0 : gl_reg + 20'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  clk_low_a: assert property ($rose(pixel_clk) |-> lo_reg == HALF_CYC && lo_reg >= PIX_PHASE_MIN_CYC)
    else $error("pixel clock low phase wrong");
  clk_high_a: assert property ($fell(pixel_clk) |-> hi_reg >= HALF_CYC)
    else $error("pixel clock high phase short");
  gate_width_a: assert property ($rose(readout_gate_n) |-> gl_reg == GATE_CYC && gl_reg >= GATE_MIN_CYC)
    else $error("gate pulse width wrong");
  gate_lead_a: assert property ($fell(readout_gate_n) |-> hi_reg >= GUARD_CYC)
    else $error("gate fell too close to clock");
  gate_trail_a: assert property ($rose(readout_gate_n) |-> pixel_clk [*2])
    else $error("clock fell too close to gate");
  gate_start_a: assert property (start && !busy |-> ##1 busy ##[1:4] $fell(readout_gate_n))
    else $error("start did not launch gate");
  mode_still_a: assert property (busy ##1 busy |-> $stable(hold_mode_select))
    else $error("mode pin moved mid line");
  strobe_fall_a: assert property (pix_valid |-> !pixel_clk && $past(pixel_clk) && !$past(pix_valid))
    else $error("strobe not at clock fall");
  region_tag_a: assert property (pix_valid |-> pix_tag.index < LINE_PIX && pix_tag.region ==
    (pix_tag.index < LEAD_DUMMY ? REGION_LEAD : pix_tag.index < LEAD_DUMMY + ACTIVE_PIX ? REGION_ACTIVE : REGION_TRAIL))
    else $error("region tag wrong");
  keep_tag_a: assert property (pix_valid |-> pix_tag.keep == !(alternate_only && pix_tag.line_odd))
    else $error("keep flag wrong");
endmodule

//--- tb/line_sensor_model.sv
// behavioural sensor plus ADC, seen from the controller's pins
// assumes the controller makes gate and pixel clock; adc_clk runs free
`timescale 1ns/1ps
module line_sensor_model
  import line_readout_pkg::*;
#(
  parameter int unsigned ADC_W = 12
) (
  input wire logic adc_clk,
  input wire logic readout_gate_n,
  input wire logic pixel_clk,
  input wire logic hold_mode_select,
  output logic [ADC_W-1:0] adc_data
);
  logic [PIX_CNT_W-1:0] pix_idx = PIX_CNT_W'(LINE_PIX);
  logic [ADC_W-1:0] video = '0, held = '0, cur;
  logic bank = 1'b0;
  initial adc_data = '0;
  // gate low: charge moves to the other bank, count restarts
  always @(negedge readout_gate_n) begin
    pix_idx = '0;
    bank = ~bank;
  end
  // spent line shows a toggling pattern of inverted video, which also repeats the last pixel
  always @(negedge pixel_clk) begin
    cur = (pix_idx < LINE_PIX) ? ADC_W'(pix_idx) + ADC_W'(bank) : ~video;
    if (!hold_mode_select) begin
      video = held;
      held = cur;
    end else video = cur;
    if (pix_idx < LINE_PIX) pix_idx = pix_idx + 1'b1;
  end
  always @(posedge adc_clk) adc_data <= video;
endmodule

//--- tb/line_readout_ctrl_tb_top.sv
// self-checking bench: controller, sensor model, bound checker
// assumes an 8 ns system clock and an unrelated 64 ns ADC clock
`timescale 1ns/1ps
module line_readout_ctrl_tb_top;
  import line_readout_pkg::*;
  logic sys_clk = 1'b0, adc_clk = 1'b0, rst = 1'b1, start = 1'b0;
  logic continuous = 1'b0, sample_hold = 1'b0, alternate_only = 1'b0, hold_exp = 1'b0;
  logic readout_gate_n, pixel_clk, hold_mode_select, busy, pix_valid, prev_clk, prev_gate, odd_exp;
  logic [11:0] adc_data, pix_data;
  logic [31:0] rnd;
  pixel_tag_t pix_tag;
  integer seed = 32'h726e05ed;
  int fails = 0, check_count = 0, cyc = 0, falls = 0, strobes = 0, idx;
  always #4 sys_clk = ~sys_clk;
  // offset so the two clock edges never coincide
  initial #3 forever #32 adc_clk = ~adc_clk;
  // shortest legal phases keep a full line near 54k cycles
  line_readout_ctrl #(.HALF_CYC(13), .GATE_CYC(63), .INTEG_CYC(70000), .ADC_W(12)) u_line_readout_ctrl (
    .sys_clk(sys_clk), .rst(rst), .adc_clk(adc_clk), .start(start), .continuous(continuous),
    .sample_hold(sample_hold), .alternate_only(alternate_only), .adc_data(adc_data),
    .readout_gate_n(readout_gate_n), .pixel_clk(pixel_clk), .hold_mode_select(hold_mode_select),
    .busy(busy), .pix_valid(pix_valid), .pix_data(pix_data), .pix_tag(pix_tag));
  line_sensor_model #(.ADC_W(12)) u_line_sensor_model (.adc_clk(adc_clk), .readout_gate_n(readout_gate_n),
    .pixel_clk(pixel_clk), .hold_mode_select(hold_mode_select), .adc_data(adc_data));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic region_t region_of(input int i);
    return i < LEAD_DUMMY ? REGION_LEAD : (i < LEAD_DUMMY + ACTIVE_PIX ? REGION_ACTIVE : REGION_TRAIL);
  endfunction
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check_idle();
    check("gate_n", 1, readout_gate_n);
    check("pixel_clk", 1, pixel_clk);
    check("mode pin", 1, hold_mode_select);
    check("busy", 0, busy);
    check("region", REGION_IDLE, pix_tag.region);
  endtask
  task automatic run_line(input logic hold, input logic alt);
    sample_hold = hold;
    alternate_only = alt;
    hold_exp = hold;
    @(negedge sys_clk) start = 1'b1;
    @(negedge sys_clk) start = 1'b0;
    check("busy", 1, busy);
  endtask
  // reference pixel count and tags, read where outputs have settled
  always @(negedge sys_clk) begin
    if (rst) odd_exp = 1'b1;
    if (!rst && prev_gate && !readout_gate_n) begin
      falls = 0;
      strobes = 0;
      odd_exp = ~odd_exp;
    end
    if (prev_clk && !pixel_clk) falls++;
    if (pix_valid) begin
      strobes++;
      idx = falls - (hold_exp ? 2 : 1);
      check("index", idx, pix_tag.index);
      check("region", region_of(idx), pix_tag.region);
      check("line_odd", odd_exp, pix_tag.line_odd);
      check("keep", !(alternate_only && odd_exp), pix_tag.keep);
      if (!hold_exp && falls > 3) check("pix_data", 1, pix_data + 3 >= falls && pix_data <= falls);
    end
    prev_clk = pixel_clk;
    prev_gate = readout_gate_n;
  end
  // ceiling: one full line plus a partial one
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    check_idle();
    rnd = $random(seed);
    repeat (rnd[3:0]) @(negedge sys_clk);
    run_line(1'b0, rnd[4]);
    @(negedge sys_clk iff busy === 1'b0);
    check("falls", LINE_PIX, falls);
    check("strobes", LINE_PIX, strobes);
    continuous = 1'b1;
    run_line(1'b1, 1'b1);
    @(negedge sys_clk iff strobes == 40);
    check("mode pin", 0, hold_mode_select);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check_idle();
    rst = 1'b0;
    wrap_up();
  end
endmodule
bind line_readout_ctrl line_readout_ctrl_asserts #(.HALF_CYC(HALF_CYC), .GATE_CYC(GATE_CYC)) u_asserts (
  .sys_clk(sys_clk), .rst(rst), .start(start), .alternate_only(alternate_only), .readout_gate_n(readout_gate_n),
  .pixel_clk(pixel_clk), .hold_mode_select(hold_mode_select), .busy(busy), .pix_valid(pix_valid), .pix_tag(pix_tag));
